// >>> src/iovfr_pkg.sv
// Package for the input overvoltage fault response block.
// Assumes a 100 MHz core clock and command codes decoded by the serial front end.
package iovfr_pkg;
  // Command codes of the configuration and status registers.
  localparam logic [7:0] CMD_FAULT_RESPONSE = 8'h56;
  localparam logic [7:0] CMD_WARN_LIMIT = 8'h57;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;

  // Reset values.
  localparam logic [7:0] FAULT_RESPONSE_RESET = 8'h80;
  localparam logic [15:0] WARN_LIMIT_RESET = 16'hD360;

  // Field positions inside the fault response byte.
  localparam int RESP_MODE_HI = 7;
  localparam int RESP_MODE_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  // Response mode and retry encodings.
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] MODE_HOLD_WHILE_FAULT = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Status bit positions.
  localparam int SW_INPUT_BIT = 13;
  localparam int SW_NONE_ABOVE_BIT = 0;
  localparam int SI_OV_FAULT_BIT = 7;
  localparam int SI_OV_WARN_BIT = 6;

  // Retry delay step and its length in clock cycles.
  localparam int CLOCK_HZ = 100000000;
  localparam int RETRY_STEP_MS = 35;
  localparam int RETRY_STEP_CYCLES = (CLOCK_HZ / 1000) * RETRY_STEP_MS;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HOLD,
    ST_LATCHED,
    ST_RETRY_WAIT
  } iovfr_state_t;
endpackage

// >>> src/iovfr_input_ov_response.sv
// Input overvoltage fault response: configuration registers, status latching,
// alert line and the disable / retry sequencer for the power stage enable.
// Assumes the fault comparator arrives asynchronously, while the warning
// compare, commands and clear strobe come from logic on the same clock.
//
// Behaviour
// (RL1) An input overvoltage fault pulls the alert line low and sets its fault status bit.
// (RL2) Latched fault status bits clear only on the clear-faults command.
// (RL3) Mode 10 in bits 7:6 disables the output and applies the retry field; 00/01 are unused.
// (RL4) Mode 11 holds the output off while the fault lasts, resuming below the warning limit.
// (RL5) Retry 000 keeps the output off until faults are cleared; 001 to 110 act alike.
// (RL6) Retry 111 retries until commanded off, power is lost or another fault shuts down.
// (RL7) A restart attempt starts only once the input is below the warning limit.
// (RL8) Attempts are spaced by (bits 2:0 plus one) times 35 ms.
// (RL9) The fault response byte resets to 80h.
// (RL10) The fault response byte is one global read/write byte that honours write protection.
// (RL11) Crossing the warning limit sets the input, catch-all and warning bits and alerts.
// (RL12) The warning limit is a global two-byte write-protectable value in linear-11 form.
// (RL13) The warning limit resets to D360h.
// (RL14) The retry delay is timed by a 35 ms prescaler tick that restarts at each attempt.
`timescale 1ns/1ns
module iovfr_input_ov_response #(
  parameter int TICK_CYCLES = iovfr_pkg::RETRY_STEP_CYCLES
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Command port from the serial front end.
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic i_clear_faults,
  input wire logic i_write_protect,
  output logic [15:0] o_cmd_rdata,
  output logic o_cmd_unmapped,
  // Monitoring and power control.
  input wire logic i_vin_ov_fault,
  input wire logic i_vin_above_warn,
  input wire logic i_output_on_cmd,
  input wire logic i_other_fault_shutdown,
  output logic o_output_enable,
  output logic [15:0] o_warn_limit,
  // Status and open-drain alert.
  output logic [15:0] o_status_word,
  output logic [7:0] o_status_input,
  output logic o_serial_alert_line_out,
  output logic o_serial_alert_line_oe
);
  logic [7:0] fault_response;
  logic [15:0] warn_limit;
  logic fault_sync1;
  logic fault_sync2;
  logic fault_prev;
  logic fault_rise;
  logic warn_prev;
  logic warn_rise;
  logic ov_fault_latched;
  logic ov_warn_latched;
  logic alert_active;
  logic [31:0] prescale;
  logic tick;
  logic [3:0] tick_count;
  logic [3:0] delay_steps;
  logic delay_done;
  logic wr_en;
  iovfr_pkg::iovfr_state_t state;
  iovfr_pkg::iovfr_state_t next_state;

  // Decodes a retry field; unused values behave as no retry.
  function automatic logic retry_forever(input logic [7:0] resp);
    retry_forever = (resp[iovfr_pkg::RETRY_HI:iovfr_pkg::RETRY_LO] == iovfr_pkg::RETRY_FOREVER);
  endfunction

  // The fault comparator is asynchronous, so it passes two flops first.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_sync1 <= 1'b0;
      fault_sync2 <= 1'b0;
      fault_prev <= 1'b0;
      warn_prev <= 1'b0;
    end else begin
      fault_sync1 <= i_vin_ov_fault;
      fault_sync2 <= fault_sync1;
      fault_prev <= fault_sync2;
      warn_prev <= i_vin_above_warn;
    end
  end

  // Events fire on the rising edge so that a held condition acts once.
  assign fault_rise = fault_sync2 && !fault_prev;
  assign warn_rise = i_vin_above_warn && !warn_prev;
  assign wr_en = i_cmd_valid && i_cmd_write && !i_write_protect;

  // Configuration registers; a protected write is dropped silently.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_response <= iovfr_pkg::FAULT_RESPONSE_RESET; // RL9
      warn_limit <= iovfr_pkg::WARN_LIMIT_RESET; // RL13
    end else if (wr_en) begin
      if (i_cmd_code == iovfr_pkg::CMD_FAULT_RESPONSE) begin
        fault_response <= i_cmd_wdata[7:0]; // RL10
      end
      if (i_cmd_code == iovfr_pkg::CMD_WARN_LIMIT) begin
        warn_limit <= i_cmd_wdata; // RL12
      end
    end
  end

  // Sticky status bits; a new event in the clearing cycle still sets them.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ov_fault_latched <= 1'b0;
      ov_warn_latched <= 1'b0;
    end else begin
      if (fault_rise) begin
        ov_fault_latched <= 1'b1; // RL1
      end else if (i_clear_faults) begin
        ov_fault_latched <= 1'b0; // RL2
      end
      if (warn_rise) begin
        ov_warn_latched <= 1'b1; // RL11
      end else if (i_clear_faults) begin
        ov_warn_latched <= 1'b0; // RL2
      end
    end
  end

  // Alert follows the latched bits, so it also releases only on clear.
  assign alert_active = ov_fault_latched || ov_warn_latched; // RL1
  assign o_serial_alert_line_out = 1'b0;
  assign o_serial_alert_line_oe = alert_active; // RL11

  // Status images; the input word bit and catch-all bit mirror any input event.
  always_comb begin
    o_status_input = 8'h00;
    o_status_input[iovfr_pkg::SI_OV_FAULT_BIT] = ov_fault_latched;
    o_status_input[iovfr_pkg::SI_OV_WARN_BIT] = ov_warn_latched;
    o_status_word = 16'h0000;
    o_status_word[iovfr_pkg::SW_INPUT_BIT] = alert_active; // RL11
    o_status_word[iovfr_pkg::SW_NONE_ABOVE_BIT] = alert_active; // RL11
  end

  // Prescaler for the 35 ms step; it restarts whenever a retry wait begins.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      prescale <= 32'h00000000;
      tick_count <= 4'h0;
    end else if (state != iovfr_pkg::ST_RETRY_WAIT) begin
      prescale <= 32'h00000000; // RL14
      tick_count <= 4'h0;
    end else if (tick) begin
      prescale <= 32'h00000000;
      if (!delay_done) begin
        tick_count <= tick_count + 4'h1;
      end
    end else begin
      prescale <= prescale + 32'h00000001;
    end
  end

  assign tick = (prescale == 32'(TICK_CYCLES - 1)); // RL14
  // Delay is (field + 1) steps; the count stops at the field value, so delay_done is true again only on each later tick
  // while the sequencer still waits for the input to fall below the warning limit.
  assign delay_steps = {1'b0, fault_response[iovfr_pkg::DELAY_HI:iovfr_pkg::DELAY_LO]};
  assign delay_done = (tick_count > delay_steps) || (tick && tick_count == delay_steps); // RL8

  // Sequencer: picks the response on a new fault seen in ST_RUN and decides when to resume.
  always_comb begin
    next_state = state;
    case (state)
      iovfr_pkg::ST_RUN: begin
        if (fault_rise) begin
          case (fault_response[iovfr_pkg::RESP_MODE_HI:iovfr_pkg::RESP_MODE_LO])
            iovfr_pkg::MODE_HOLD_WHILE_FAULT: begin
              next_state = iovfr_pkg::ST_HOLD; // RL4
            end
            iovfr_pkg::MODE_DISABLE_RETRY: begin
              if (retry_forever(fault_response)) begin
                next_state = iovfr_pkg::ST_RETRY_WAIT; // RL6
              end else begin
                next_state = iovfr_pkg::ST_LATCHED; // RL5
              end
            end
            default: begin
              next_state = iovfr_pkg::ST_RUN; // RL3
            end
          endcase
        end
      end
      iovfr_pkg::ST_HOLD: begin
        if (!fault_sync2 && !i_vin_above_warn) begin
          next_state = iovfr_pkg::ST_RUN; // RL4
        end
      end
      iovfr_pkg::ST_LATCHED: begin
        if (i_clear_faults && !fault_rise) begin
          next_state = iovfr_pkg::ST_RUN; // RL5
        end
      end
      iovfr_pkg::ST_RETRY_WAIT: begin
        if (!i_output_on_cmd || i_other_fault_shutdown) begin
          next_state = iovfr_pkg::ST_LATCHED; // RL6
        end else if (delay_done && !i_vin_above_warn && !fault_sync2) begin
          next_state = iovfr_pkg::ST_RUN; // RL7
        end
      end
      default: begin
        next_state = iovfr_pkg::ST_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= iovfr_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Output enable comes from a flop so the power stage never sees a glitch.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_output_enable <= 1'b0;
    end else begin
      o_output_enable <= (next_state == iovfr_pkg::ST_RUN) && i_output_on_cmd
        && !i_other_fault_shutdown; // RL3
    end
  end

  // Read port: data is registered one cycle after the request.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cmd_rdata <= 16'h0000;
      o_cmd_unmapped <= 1'b0;
    end else if (i_cmd_valid) begin
      o_cmd_unmapped <= 1'b0;
      case (i_cmd_code)
        iovfr_pkg::CMD_FAULT_RESPONSE: o_cmd_rdata <= {8'h00, fault_response};
        iovfr_pkg::CMD_WARN_LIMIT: o_cmd_rdata <= warn_limit;
        iovfr_pkg::CMD_STATUS_WORD: o_cmd_rdata <= o_status_word;
        iovfr_pkg::CMD_STATUS_INPUT: o_cmd_rdata <= {8'h00, o_status_input};
        default: begin
          o_cmd_rdata <= 16'h0000;
          o_cmd_unmapped <= 1'b1;
        end
      endcase
    end else begin
      o_cmd_unmapped <= 1'b0;
    end
  end

  assign o_warn_limit = warn_limit;
endmodule

// >>> sim/iovfr_checker.sv
// Checker for the input overvoltage fault response block.
// Sees only the top module ports and is attached by bind.
`timescale 1ns/1ns
module iovfr_checker (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_resetn,
  // Watched inputs.
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic i_write_protect,
  input wire logic i_clear_faults,
  input wire logic i_vin_ov_fault,
  input wire logic i_vin_above_warn,
  input wire logic i_output_on_cmd,
  input wire logic i_other_fault_shutdown,
  // Watched outputs.
  input wire logic o_output_enable,
  input wire logic o_cmd_unmapped,
  input wire logic [15:0] o_status_word,
  input wire logic [7:0] o_status_input,
  input wire logic o_serial_alert_line_out,
  input wire logic o_serial_alert_line_oe
);
  logic resp_mode_hi;

  // Shadow of the upper mode bit: only modes 10 and 11 may turn the output off on a fault.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      resp_mode_hi <= 1'b1;
    end else if (i_cmd_valid && i_cmd_write && !i_write_protect && i_cmd_code == 8'h56) begin
      resp_mode_hi <= i_cmd_wdata[7];
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // A fault held this long has crossed the synchroniser and taken effect.
  sequence fault_held;
    i_vin_ov_fault [*5];
  endsequence
  a_fault_sets_status: assert property (fault_held |->
    o_status_input[7] && o_serial_alert_line_oe)
    else $error("fault status or alert missing");
  a_fault_output_off: assert property (fault_held |->
    !resp_mode_hi || !o_output_enable)
    else $error("output still on during fault");
  a_status_sticky: assert property (o_status_input[7] && !i_clear_faults |=>
    o_status_input[7])
    else $error("fault status cleared without command");
  a_alert_drive_low: assert property (o_serial_alert_line_out == 1'b0)
    else $error("alert line driven high");
  a_warn_sets_bits: assert property ($rose(i_vin_above_warn) |=> o_status_input[6]
    && o_status_word[13] && o_status_word[0] && o_serial_alert_line_oe)
    else $error("warning status missing");
  a_off_cmd_blocks: assert property (!i_output_on_cmd || i_other_fault_shutdown |=>
    !o_output_enable)
    else $error("output on while commanded off");
  a_restart_below_warn: assert property ($rose(o_output_enable) |->
    !$past(i_vin_above_warn))
    else $error("output restarted above warning limit");
  a_unmapped_flag: assert property (i_cmd_valid && i_cmd_code == 8'h20 |=>
    o_cmd_unmapped)
    else $error("unmapped command not flagged");
endmodule

bind iovfr_input_ov_response iovfr_checker iovfr_checker_inst (.i_clock, .i_resetn,
  .i_cmd_valid, .i_cmd_write, .i_cmd_code, .i_cmd_wdata, .i_write_protect,
  .i_clear_faults, .i_vin_ov_fault, .i_vin_above_warn,
  .i_output_on_cmd, .i_other_fault_shutdown, .o_output_enable, .o_cmd_unmapped,
  .o_status_word, .o_status_input, .o_serial_alert_line_out, .o_serial_alert_line_oe);

// >>> sim/iovfr_host_model.sv
// Host side model: issues command port transfers one at a time.
// Assumes the bench calls xfer from a single process.
`timescale 1ns/1ns
module iovfr_host_model (
  // Clock.
  input wire logic i_clock,
  // Command port toward the block.
  output logic o_valid,
  output logic o_write,
  output logic [7:0] o_code,
  output logic [15:0] o_wdata,
  input wire logic [15:0] i_rdata
);
  // Idle values at time zero.
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code = 8'h00;
    o_wdata = 16'h0000;
  end
  // The strobe lives for one rising edge; released data is inverted so it never looks held.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd);
    @(negedge i_clock);
    o_valid = 1'b1;
    o_write = wr;
    o_code = code;
    o_wdata = wd;
    @(negedge i_clock);
    o_valid = 1'b0;
    o_wdata = ~wd;
    rd = i_rdata;
  endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the input overvoltage fault response block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module testbench;
  localparam int TICK = 4;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic clr = 1'b0, wp = 1'b0, fault = 1'b0, warn = 1'b0, on = 1'b1, shut = 1'b0;
  logic valid, write, unm, en, aout, aoe;
  logic [7:0] code, si;
  logic [15:0] wdata, rdata, lim, sw, rd, r;
  int n_errors = 0, num_checks = 0, seed = 67678, n;
  // Free running 100 MHz clock.
  always #5 i_clock = ~i_clock;
  iovfr_input_ov_response #(.TICK_CYCLES(TICK)) iovfr_input_ov_response_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_cmd_valid(valid), .i_cmd_write(write),
    .i_cmd_code(code), .i_cmd_wdata(wdata), .i_clear_faults(clr), .i_write_protect(wp),
    .o_cmd_rdata(rdata), .o_cmd_unmapped(unm), .i_vin_ov_fault(fault),
    .i_vin_above_warn(warn), .i_output_on_cmd(on), .i_other_fault_shutdown(shut),
    .o_output_enable(en), .o_warn_limit(lim), .o_status_word(sw), .o_status_input(si),
    .o_serial_alert_line_out(aout), .o_serial_alert_line_oe(aoe));
  iovfr_host_model iovfr_host_model_inst (.i_clock(i_clock), .o_valid(valid),
    .o_write(write), .o_code(code), .o_wdata(wdata), .i_rdata(rdata));
  // Expected spacing between retry attempts in clock cycles.
  function automatic int exp_gap(input int d);
    return (d + 1) * TICK;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clock);
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    iovfr_host_model_inst.xfer(w, c, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    cmd(1'b0, c, 16'h0000);
    `CHK(rd, e)
  endtask
  task automatic clear;
    @(negedge i_clock) clr = 1'b1;
    @(negedge i_clock) clr = 1'b0;
  endtask
  // Bounded wait, so a stuck enable shows up as a mismatch instead of a hang.
  task automatic wait_en(input logic v);
    n = 0;
    while (en !== v && n < 2000) begin
      @(negedge i_clock);
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog far beyond the expected few hundred cycles.
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    cyc(10);
    i_resetn = 1'b1;
    cyc(2);
    rd_chk(8'h56, 16'h0080);
    rd_chk(8'h57, 16'hD360);
    r = 16'($random(seed));
    cmd(1'b1, 8'h57, r);
    rd_chk(8'h57, r);
    wp = 1'b1;
    cmd(1'b1, 8'h57, ~r);
    cmd(1'b1, 8'h56, 16'h00C0);
    wp = 1'b0;
    rd_chk(8'h57, r);
    `CHK(lim, r)
    rd_chk(8'h56, 16'h0080);
    cmd(1'b1, 8'h56, {r[15:8], 8'h80});
    rd_chk(8'h56, 16'h0080);
    cmd(1'b0, 8'h20, 16'h0000);
    $display("done: registers");
    warn = 1'b1;
    cyc(2);
    `CHK({si[6], sw[13], sw[0], aoe}, 4'hF)
    warn = 1'b0;
    clear();
    `CHK(si, 8'h00)
    $display("done: warning");
    // An unused retry value drawn at random must behave as no retry.
    n = $random(seed);
    n = 1 + (n & 7) % 6;
    cmd(1'b1, 8'h56, {8'h00, 2'b10, n[2:0], 3'h0});
    fault = 1'b1;
    cyc(6);
    fault = 1'b0;
    cyc(20);
    `CHK({en, si[7], aoe}, 3'h3)
    clear();
    cyc(2);
    `CHK({en, si[7]}, 2'h2)
    $display("done: no retry");
    cmd(1'b1, 8'h56, 16'h00C0);
    fault = 1'b1;
    warn = 1'b1;
    cyc(6);
    fault = 1'b0;
    cyc(10);
    `CHK(en, 1'b0)
    warn = 1'b0;
    wait_en(1'b1);
    `CHK(n < 6, 1'b1)
    clear();
    $display("done: hold while fault");
    cmd(1'b1, 8'h56, 16'h003F);
    fault = 1'b1;
    cyc(6);
    fault = 1'b0;
    cyc(2);
    `CHK({en, si[7], aoe}, 3'h7)
    clear();
    $display("done: unused mode");
    for (int d = 0; d < 8; d++) begin
      cmd(1'b1, 8'h56, {8'h00, 2'b10, 3'b111, d[2:0]});
      fault = 1'b1;
      wait_en(1'b0);
      fault = 1'b0;
      wait_en(1'b1);
      `CHK(n >= exp_gap(d) - 1 && n <= exp_gap(d) + 3, 1'b1)
    end
    // First cut by the on command, then by another fault's shutdown.
    for (int k = 0; k < 2; k++) begin
      fault = 1'b1;
      wait_en(1'b0);
      fault = 1'b0;
      on = k[0];
      shut = k[0];
      cyc(40);
      `CHK(en, 1'b0)
      on = 1'b1;
      shut = 1'b0;
      cyc(4);
      `CHK(en, 1'b0)
      clear();
      wait_en(1'b1);
      `CHK(en, 1'b1)
    end
    $display("done: retry");
    report_and_stop();
  end
endmodule
